// ### core/radio_cs_pkg.sv
/*
  radio_cs_pkg: register offsets, field positions, reset values, state codes and timing constants
  for the carrier sense / clear channel / radio state controller.
  assumes a 125 MHz system clock and a 32-bit Avalon-MM register bus.
*/
package radio_cs_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_AGC_CTRL = 8'h00;
  localparam logic [7:0] OFF_CHAN_CTRL = 8'h04;
  localparam logic [7:0] OFF_OSC_CTRL = 8'h08;
  localparam logic [7:0] OFF_STROBE = 8'h0C;
  localparam logic [7:0] OFF_PKT_STATUS = 8'h10;
  localparam logic [7:0] OFF_SIG_STATUS = 8'h14;
  localparam logic [7:0] OFF_LQI_STATUS = 8'h18;
  localparam logic [7:0] OFF_STATE_STATUS = 8'h1C;
  localparam logic [7:0] OFF_FLAGS = 8'h20;

  // strobe register bit positions
  localparam int STB_RESET = 0;
  localparam int STB_IDLE = 1;
  localparam int STB_TX = 2;
  localparam int STB_SYNTH = 3;
  localparam int STB_PWD = 4;
  localparam int STB_WOR = 5;
  localparam int STB_XOFF = 6;
  localparam int STB_RX = 7;

  // reset values
  localparam logic [3:0] RST_ABS_ADJ = 4'h0;
  localparam logic [1:0] RST_REL_SEL = 2'h0;
  localparam logic [2:0] RST_FRONT_GAIN = 3'h0;
  localparam logic [1:0] RST_DIG_GAIN = 2'h0;
  localparam logic [2:0] RST_MAGN = 3'h3;
  localparam logic [1:0] RST_CCA_MODE = 2'h3;
  localparam logic [2:0] RST_SYNC_MODE = 3'h2;
  localparam logic [5:0] RST_DOUT_SEL = 6'h29;
  localparam logic RST_FORCE_ON = 1'b0;
  localparam logic RST_OSC_OFF = 1'b1;

  // digital output select codes
  localparam logic [5:0] DOUT_CCA = 6'h09;
  localparam logic [5:0] DOUT_CS = 6'h0E;
  localparam logic [5:0] DOUT_RDY = 6'h29;

  // signal strength: two's complement, half-dB units
  localparam logic [7:0] HYST_HALF_DB = 8'h02;
  localparam logic [7:0] BASE_THRESH = 8'hBB;
  localparam logic [7:0] STEP_6DB = 8'h0C;
  localparam logic [7:0] STEP_10DB = 8'h14;
  localparam logic [7:0] STEP_14DB = 8'h1C;
  localparam logic [6:0] LQI_SYMBOLS = 7'h40;

  // oscillator start-up
  localparam int OSC_START_US = 810;
  localparam int CLK_MHZ = 125;
  localparam int OSC_START_CYC = OSC_START_US * CLK_MHZ;

  typedef enum logic [2:0] {
    ST_SLEEP = 3'b000,
    ST_WAKE = 3'b001,
    ST_IDLE = 3'b011,
    ST_RX = 3'b010,
    ST_SYNTH = 3'b110,
    ST_TX = 3'b111
  } radio_state_t;

  localparam logic [4:0] NUM_SLEEP = 5'h00;
  localparam logic [4:0] NUM_WAKE = 5'h02;
  localparam logic [4:0] NUM_IDLE = 5'h01;
  localparam logic [4:0] NUM_RX = 5'h0D;
  localparam logic [4:0] NUM_SYNTH = 5'h12;
  localparam logic [4:0] NUM_TX = 5'h13;

  typedef struct packed {
    logic [3:0] abs_threshold_adjust;
    logic [1:0] rel_threshold_select;
    logic [2:0] max_front_gain;
    logic [1:0] max_digital_gain;
    logic [2:0] target_magnitude;
  } agc_cfg_t;

  typedef struct packed {
    logic valid;
    logic [7:0] strength;
  } rssi_sample_t;

endpackage

// ### core/carrier_detect.sv
/*
  carrier_detect: absolute and relative carrier sense from signal strength samples.
  assumes samples arrive as one-cycle valid pulses on clk; strength is two's complement half-dB.
*/
`timescale 1ns/1ps
module carrier_detect
  import radio_cs_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic soft_rst,
  // config and samples
  input wire agc_cfg_t cfg,
  input wire rssi_sample_t sample,
  // result
  output logic carrier_q,
  output logic below_thr_q
);

  logic [7:0] prev_q;
  logic have_prev_q;
  logic abs_cs_q;
  logic rel_cs_q;
  logic signed [9:0] thr;
  logic signed [9:0] cur;
  logic signed [9:0] diff;
  logic [7:0] step;

  // max gains raise the point by the combined gain; 1 dB is two half-dB units
  always_comb begin
    thr = 10'(signed'(BASE_THRESH)) + 10'(signed'({1'b0, cfg.max_front_gain, 1'b0}))
        + 10'(signed'({1'b0, cfg.max_digital_gain, 2'b00}))
        + 10'(signed'({cfg.abs_threshold_adjust, 1'b0}));
    cur = 10'(signed'(sample.strength));
    diff = cur - 10'(signed'(prev_q));
    case (cfg.rel_threshold_select)
      2'h1: step = STEP_6DB;
      2'h2: step = STEP_10DB;
      2'h3: step = STEP_14DB;
      default: step = 8'h00;
    endcase
  end

  // band avoids chatter on samples near the threshold
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      abs_cs_q <= 1'b0;
    end else if (soft_rst) begin
      abs_cs_q <= 1'b0;
    end else if (sample.valid) begin
      // signed casts: one unsigned operand would turn the compare unsigned
      if (cur > thr + signed'(10'(HYST_HALF_DB))) begin
        abs_cs_q <= 1'b1;
      end else if (cur < thr - signed'(10'(HYST_HALF_DB))) begin
        abs_cs_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prev_q <= 8'h00;
      have_prev_q <= 1'b0;
      rel_cs_q <= 1'b0;
    end else if (soft_rst) begin
      prev_q <= 8'h00;
      have_prev_q <= 1'b0;
      rel_cs_q <= 1'b0;
    end else if (sample.valid) begin
      prev_q <= sample.strength;
      have_prev_q <= 1'b1;
      if (step == 8'h00) begin
        rel_cs_q <= 1'b0;
      end else if (have_prev_q && diff >= signed'(10'(step))) begin
        rel_cs_q <= 1'b1;
      end else if (have_prev_q && diff <= -signed'(10'(step))) begin
        rel_cs_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      carrier_q <= 1'b0;
      below_thr_q <= 1'b1;
    end else begin
      carrier_q <= abs_cs_q | rel_cs_q;
      below_thr_q <= ~abs_cs_q;
    end
  end

  AST_REL_OFF: assert property (@(posedge clk) disable iff (!nrst)
    (cfg.rel_threshold_select == 2'h0) && sample.valid |=> !rel_cs_q)
    else $error("relative sense active while disabled");

endmodule

// ### core/link_quality.sv
/*
  link_quality: accumulates error magnitude over the symbols after sync.
  assumes sync_found pulses once per packet and sym_valid marks each demodulated symbol.
*/
`timescale 1ns/1ps
module link_quality
  import radio_cs_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic soft_rst,
  // demodulator
  input wire logic sync_found,
  input wire logic sym_valid,
  input wire logic [7:0] sym_error,
  // result
  output logic [6:0] lqi_q,
  output logic lqi_done_q
);

  logic [6:0] cnt_q;
  logic [13:0] acc_q;
  logic busy_q;

  // lower sum means a cleaner link; sum shifted right by seven into seven bits
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 7'h00;
      acc_q <= 14'h0000;
      busy_q <= 1'b0;
      lqi_q <= 7'h7F;
      lqi_done_q <= 1'b0;
    end else if (soft_rst) begin
      cnt_q <= 7'h00;
      acc_q <= 14'h0000;
      busy_q <= 1'b0;
      lqi_q <= 7'h7F;
      lqi_done_q <= 1'b0;
    end else begin
      lqi_done_q <= 1'b0;
      if (sync_found) begin
        cnt_q <= 7'h00;
        acc_q <= 14'h0000;
        busy_q <= 1'b1;
      end else if (busy_q && sym_valid) begin
        acc_q <= acc_q + 14'(sym_error);
        cnt_q <= cnt_q + 7'h01;
        if (cnt_q + 7'h01 == LQI_SYMBOLS) begin
          busy_q <= 1'b0;
          lqi_done_q <= 1'b1;
          lqi_q <= 7'((acc_q + 14'(sym_error)) >> 7);
        end
      end
    end
  end

  AST_LQI_COUNT: assert property (@(posedge clk) disable iff (!nrst || soft_rst)
    lqi_done_q |-> $past(cnt_q) == LQI_SYMBOLS - 7'h01)
    else $error("link quality finished after wrong symbol count");

endmodule

// ### core/radio_cs_ctrl.sv
/*
  radio_cs_ctrl: register file, strobe-driven radio state machine, clear channel gating,
  carrier sense outputs, link quality report and crystal oscillator control.
  assumes an Avalon-MM master on clk; radio pin inputs arrive unsynchronised.
*/
// Design decisions made here: the Avalon-MM slave port and the register addresses.
// Behaviour
// - absolute mode: strength above threshold sets sense
// - relative mode: step rise sets, drop clears
// - sync search gated by carrier sense qualifier
// - sense on flag, output code 14, status
// - threshold adjust moves point by 1 dB
// - relative step disabled or 6/10/14 dB
// - clear channel on flag and code 0x09
// - transmit strobe in receive needs clear channel
// - refused strobe never retried automatically
// - four clear channel modes
// - quality sums error over 64 symbols
// - quality appended and readable in status
// - state changes on strobes/events, number reported
// - global reset strobe restores defaults, sleeps
// - oscillator forced on by either control
// - power-down strobes stop oscillator from idle
// - leaving sleep restarts oscillator, 810 us
// - forced oscillator runs during sleep
// - reset: sleep, oscillator off, defaults
// - strength status is signed half-dB dBm
// - sync codes 100-111 add carrier sense
`timescale 1ns/1ps
module radio_cs_ctrl
  import radio_cs_pkg::*;
#(
  parameter int OSC_WAIT = OSC_START_CYC
)(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // avalon-mm slave
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // demodulator side (pins)
  input wire logic rssi_valid_pin,
  input wire logic [7:0] rssi_pin,
  input wire logic sync_match_pin,
  input wire logic pkt_active_pin,
  input wire logic sym_valid_pin,
  input wire logic [7:0] sym_error_pin,
  input wire logic tx_underflow_pin,
  input wire logic pkt_end_pin,
  // radio outputs
  output logic sync_search_en,
  output logic sync_found,
  output logic osc_enable,
  output logic radio_ready_low,
  output logic digital_out,
  output logic carrier_flag_irq,
  output logic clear_channel_flag_irq,
  output logic [7:0] status_append_byte,
  output logic status_append_valid
);

  agc_cfg_t agc_q;
  logic [1:0] clear_channel_mode_q;
  logic [2:0] sync_mode_q;
  logic [5:0] digital_out_select_q;
  logic append_status_enable_q;
  logic osc_force_on_q;
  logic osc_off_control_q;
  radio_state_t state_q;
  logic [16:0] osc_cnt_q;
  logic soft_rst;
  logic [7:0] strobe;
  logic wr_acc;
  logic rd_pend_q;
  logic [7:0] rssi_q;
  logic carrier, below_thr, cca_ok, forced_on, rdy_low;
  logic [6:0] link_quality_value;
  logic lqi_done;
  logic [4:0] state_num;

  // two-flop synchronisers on every pin except the packet end pin; flop one feeds flop two only
  logic [20:0] pin_s1_q, pin_s2_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_s1_q <= 21'h000000;
      pin_s2_q <= 21'h000000;
    end else begin
      // packet end comes from falling packet-active, so the end pin is not synchronised
      pin_s1_q <= {rssi_valid_pin, rssi_pin, sync_match_pin, pkt_active_pin, sym_valid_pin,
                   sym_error_pin, tx_underflow_pin};
      pin_s2_q <= pin_s1_q;
    end
  end
  wire rssi_valid_s = pin_s2_q[20];
  wire [7:0] rssi_s = pin_s2_q[19:12];
  wire sync_match_s = pin_s2_q[11];
  wire pkt_active_s = pin_s2_q[10];
  wire sym_valid_s = pin_s2_q[9];
  wire [7:0] sym_err_s = pin_s2_q[8:1];
  wire tx_under_s = pin_s2_q[0];

  logic pkt_end_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pkt_end_q <= 1'b0;
    end else begin
      pkt_end_q <= pkt_active_s;
    end
  end

  // bus: writes and reads answer with waitrequest low in the request cycle for writes,
  // one cycle later for reads (registered read data)
  assign wr_acc = write;
  assign waitrequest = read & ~rd_pend_q;
  assign strobe = (wr_acc && address == OFF_STROBE && byteenable[0]) ? writedata[7:0] : 8'h00;
  assign soft_rst = strobe[STB_RESET];

  function automatic logic sel_hit(input logic [7:0] a, input logic [7:0] off);
    sel_hit = (a == off);
  endfunction

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      agc_q <= '{RST_ABS_ADJ, RST_REL_SEL, RST_FRONT_GAIN, RST_DIG_GAIN, RST_MAGN};
      clear_channel_mode_q <= RST_CCA_MODE;
      sync_mode_q <= RST_SYNC_MODE;
      digital_out_select_q <= RST_DOUT_SEL;
      append_status_enable_q <= 1'b0;
      osc_force_on_q <= RST_FORCE_ON;
      osc_off_control_q <= RST_OSC_OFF;
    end else if (soft_rst) begin
      agc_q <= '{RST_ABS_ADJ, RST_REL_SEL, RST_FRONT_GAIN, RST_DIG_GAIN, RST_MAGN};
      clear_channel_mode_q <= RST_CCA_MODE;
      sync_mode_q <= RST_SYNC_MODE;
      digital_out_select_q <= RST_DOUT_SEL;
      append_status_enable_q <= 1'b0;
      osc_force_on_q <= RST_FORCE_ON;
      osc_off_control_q <= RST_OSC_OFF;
    end else if (wr_acc) begin
      if (sel_hit(address, OFF_AGC_CTRL) && byteenable[1:0] == 2'b11) begin
        agc_q <= writedata[13:0];
      end else if (sel_hit(address, OFF_CHAN_CTRL) && byteenable[1:0] == 2'b11) begin
        clear_channel_mode_q <= writedata[1:0];
        sync_mode_q <= writedata[4:2];
        append_status_enable_q <= writedata[5];
        digital_out_select_q <= writedata[13:8];
      end else if (sel_hit(address, OFF_OSC_CTRL) && byteenable[0]) begin
        osc_force_on_q <= writedata[0];
        osc_off_control_q <= writedata[1];
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_pend_q <= 1'b0;
      readdata <= 32'h00000000;
    end else begin
      rd_pend_q <= read & ~rd_pend_q;
      if (read && !rd_pend_q) begin
        if (sel_hit(address, OFF_AGC_CTRL)) begin
          readdata <= {18'h00000, agc_q};
        end else if (sel_hit(address, OFF_CHAN_CTRL)) begin
          readdata <= {18'h00000, digital_out_select_q, 2'b00, append_status_enable_q, sync_mode_q,
                       clear_channel_mode_q};
        end else if (sel_hit(address, OFF_OSC_CTRL)) begin
          readdata <= {30'h00000000, osc_off_control_q, osc_force_on_q};
        end else if (sel_hit(address, OFF_PKT_STATUS)) begin
          readdata <= {28'h0000000, ~below_thr, cca_ok, carrier, digital_out};
        end else if (sel_hit(address, OFF_SIG_STATUS)) begin
          readdata <= {24'h000000, rssi_q};
        end else if (sel_hit(address, OFF_LQI_STATUS)) begin
          readdata <= {25'h0000000, link_quality_value};
        end else if (sel_hit(address, OFF_STATE_STATUS)) begin
          readdata <= {27'h0000000, state_num};
        end else if (sel_hit(address, OFF_FLAGS)) begin
          readdata <= {29'h00000000, radio_ready_low, clear_channel_flag_irq, carrier_flag_irq};
        end else begin
          readdata <= 32'h00000000;
        end
      end
    end
  end

  // strength register holds the raw two's complement sample
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rssi_q <= 8'h80;
    end else if (soft_rst) begin
      rssi_q <= 8'h80;
    end else if (rssi_valid_s) begin
      rssi_q <= rssi_s;
    end
  end

  carrier_detect u_cs (
    .clk(clk),
    .nrst(nrst),
    .soft_rst(soft_rst),
    .cfg(agc_q),
    .sample('{rssi_valid_s, rssi_s}),
    .carrier_q(carrier),
    .below_thr_q(below_thr)
  );

  link_quality u_lqi (
    .clk(clk),
    .nrst(nrst),
    .soft_rst(soft_rst),
    .sync_found(sync_found),
    .sym_valid(sym_valid_s),
    .sym_error(sym_err_s),
    .lqi_q(link_quality_value),
    .lqi_done_q(lqi_done)
  );

  always_comb begin
    case (clear_channel_mode_q)
      2'h0: cca_ok = 1'b1;
      2'h1: cca_ok = below_thr;
      2'h2: cca_ok = ~pkt_active_s;
      default: cca_ok = below_thr & ~pkt_active_s;
    endcase
  end

  // sync search qualified by carrier sense for codes 100-111
  assign sync_search_en = (state_q == ST_RX) && (!sync_mode_q[2] || carrier);
  assign sync_found = sync_search_en && sync_match_s && (sync_mode_q[1:0] != 2'b00);

  assign carrier_flag_irq = carrier;
  assign clear_channel_flag_irq = cca_ok;
  assign forced_on = osc_force_on_q | ~osc_off_control_q;
  assign rdy_low = ~(state_q != ST_SLEEP && state_q != ST_WAKE);
  assign radio_ready_low = rdy_low;

  always_comb begin
    if (digital_out_select_q == DOUT_CS) begin
      digital_out = carrier;
    end else if (digital_out_select_q == DOUT_CCA) begin
      digital_out = cca_ok;
    end else if (digital_out_select_q == DOUT_RDY) begin
      digital_out = rdy_low;
    end else begin
      digital_out = 1'b0;
    end
  end

  // oscillator runs outside sleep, or always when forced
  assign osc_enable = forced_on || state_q != ST_SLEEP;

  // state machine: strobe is a one-cycle pulse; a refused transmit is simply dropped
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_SLEEP;
      osc_cnt_q <= 17'h00000;
    end else if (soft_rst) begin
      state_q <= ST_SLEEP;
      osc_cnt_q <= 17'h00000;
    end else begin
      case (state_q)
        ST_SLEEP: begin
          if (strobe[STB_IDLE]) begin
            state_q <= forced_on ? ST_IDLE : ST_WAKE;
            osc_cnt_q <= 17'(OSC_WAIT - 1);
          end
        end
        ST_WAKE: begin
          if (osc_cnt_q == 17'h00000) begin
            state_q <= ST_IDLE;
          end else begin
            osc_cnt_q <= osc_cnt_q - 17'h00001;
          end
        end
        ST_IDLE: begin
          if (strobe[STB_PWD] || strobe[STB_WOR] || strobe[STB_XOFF]) begin
            state_q <= ST_SLEEP;
          end else if (strobe[STB_RX]) begin
            state_q <= ST_RX;
          end else if (strobe[STB_TX]) begin
            state_q <= ST_TX;
          end else if (strobe[STB_SYNTH]) begin
            state_q <= ST_SYNTH;
          end
        end
        ST_RX: begin
          if (strobe[STB_IDLE]) begin
            state_q <= ST_IDLE;
          end else if (strobe[STB_TX] && cca_ok) begin
            state_q <= ST_TX;
          end else if (strobe[STB_SYNTH] && cca_ok) begin
            state_q <= ST_SYNTH;
          end
        end
        ST_SYNTH: begin
          if (strobe[STB_IDLE]) begin
            state_q <= ST_IDLE;
          end else if (strobe[STB_TX]) begin
            state_q <= ST_TX;
          end else if (strobe[STB_RX]) begin
            state_q <= ST_RX;
          end
        end
        ST_TX: begin
          if (strobe[STB_IDLE] || tx_under_s) begin
            state_q <= ST_IDLE;
          end else if (strobe[STB_RX]) begin
            state_q <= ST_RX;
          end
        end
        default: state_q <= ST_SLEEP;
      endcase
    end
  end

  always_comb begin
    case (state_q)
      ST_SLEEP: state_num = NUM_SLEEP;
      ST_WAKE: state_num = NUM_WAKE;
      ST_IDLE: state_num = NUM_IDLE;
      ST_RX: state_num = NUM_RX;
      ST_SYNTH: state_num = NUM_SYNTH;
      default: state_num = NUM_TX;
    endcase
  end

  // appended status: strength byte then quality byte at packet end
  logic [1:0] app_phase_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      app_phase_q <= 2'b00;
      status_append_byte <= 8'h00;
      status_append_valid <= 1'b0;
    end else begin
      status_append_valid <= 1'b0;
      if (append_status_enable_q && pkt_end_q && !pkt_active_s) begin
        status_append_byte <= rssi_q;
        status_append_valid <= 1'b1;
        app_phase_q <= 2'b01;
      end else if (app_phase_q == 2'b01) begin
        status_append_byte <= {1'b0, link_quality_value};
        status_append_valid <= 1'b1;
        app_phase_q <= 2'b00;
      end
    end
  end

  AST_CCA_REFUSE: assert property (@(posedge clk) disable iff (!nrst)
    state_q == ST_RX && strobe[STB_TX] && !cca_ok && !strobe[STB_IDLE] && !soft_rst |=> state_q == ST_RX)
    else $error("transmit entered without clear channel");
  AST_NO_AUTO_TX: assert property (@(posedge clk) disable iff (!nrst)
    state_q == ST_RX && !strobe[STB_TX] |=> state_q != ST_TX)
    else $error("transmit entered without strobe");
  AST_STROBE_GLOBAL_RESET: assert property (@(posedge clk) disable iff (!nrst)
    soft_rst |=> state_q == ST_SLEEP && !osc_force_on_q && osc_off_control_q)
    else $error("global reset strobe did not restore defaults");
  AST_FORCE_ON: assert property (@(posedge clk) disable iff (!nrst)
    forced_on |-> osc_enable)
    else $error("forced oscillator stopped");
  AST_PWD_IDLE: assert property (@(posedge clk) disable iff (!nrst)
    state_q == ST_IDLE && strobe[STB_PWD] && !soft_rst |=> state_q == ST_SLEEP && (osc_enable == forced_on))
    else $error("power-down strobe from idle ignored");
  AST_PWD_BUSY: assert property (@(posedge clk) disable iff (!nrst)
    state_q == ST_TX && !strobe[STB_IDLE] && !tx_under_s && !soft_rst && !strobe[STB_RX] |=> state_q == ST_TX)
    else $error("transmit left without cause");
  AST_GDO_CS: assert property (@(posedge clk) disable iff (!nrst)
    digital_out_select_q == DOUT_CS |-> digital_out == carrier_flag_irq)
    else $error("digital output not showing carrier sense");
  AST_GDO_CCA: assert property (@(posedge clk) disable iff (!nrst)
    digital_out_select_q == DOUT_CCA |-> digital_out == clear_channel_flag_irq)
    else $error("digital output not showing clear channel");
  AST_SYNC_QUAL: assert property (@(posedge clk) disable iff (!nrst)
    sync_mode_q[2] && !carrier |-> !sync_search_en)
    else $error("sync search without carrier sense");
  AST_CCA_MODE: assert property (@(posedge clk) disable iff (!nrst)
    clear_channel_mode_q == 2'h0 |-> cca_ok)
    else $error("always-clear mode reported busy");

endmodule

// ### verif/rssi_source.sv
/*
  rssi_source: demodulator-side model that feeds signal strength samples.
  assumes level is two's complement half-dB; one sample pulse every 8 clocks.
*/
`timescale 1ns/1ps
module rssi_source (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // requested strength
  input wire logic [7:0] level,
  // pins
  output logic valid,
  output logic [7:0] rssi
);
  logic [2:0] cnt_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 3'h0;
    end else begin
      cnt_q <= cnt_q + 3'h1;
    end
  end
  assign valid = (cnt_q == 3'h7);
  // bus not held between samples, so show the inverse
  assign rssi = valid ? level : ~level;
endmodule

// ### verif/radio_cs_ctrl_tb_top.sv
/*
  radio_cs_ctrl_tb_top: self-checking bench over Avalon-MM with a sample source.
  assumes OSC_WAIT shortened to 16 cycles; clk at 125 MHz.
*/
`timescale 1ns/1ps
module radio_cs_ctrl_tb_top;
  import radio_cs_pkg::*;
  logic clk = 0, nrst = 0, read = 0, write = 0, pkt = 0, txu = 0;
  logic [7:0] address = 8'h00, level = 8'h80;
  logic [31:0] writedata = 32'h0, rdv;
  logic [15:0] lfsr = 16'h4FBA;
  wire logic rv, cs, cca, rdy, osc, dout, wreq, sse, av;
  wire logic [7:0] rssi, ab;
  wire logic [31:0] rdata;
  int num_errors = 0, tests_run = 0, m;
  always #4 clk = ~clk;
  rssi_source u_rssi_source (.clk(clk), .nrst(nrst), .level(level), .valid(rv), .rssi(rssi));
  radio_cs_ctrl #(.OSC_WAIT(16)) u_radio_cs_ctrl (.clk(clk), .nrst(nrst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(4'hF), .readdata(rdata), .waitrequest(wreq),
    .rssi_valid_pin(rv), .rssi_pin(rssi), .sync_match_pin(1'b0), .pkt_active_pin(pkt), .sym_valid_pin(1'b0),
    .sym_error_pin(lfsr[7:0]), .tx_underflow_pin(txu), .pkt_end_pin(1'b0), .sync_search_en(sse), .sync_found(),
    .osc_enable(osc), .radio_ready_low(rdy), .digital_out(dout), .carrier_flag_irq(cs),
    .clear_channel_flag_irq(cca), .status_append_byte(ab), .status_append_valid(av));
  function automatic logic [15:0] next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // host-side reading: codes from 128 up are negative half-dB
  function automatic logic [31:0] half_db(input logic [7:0] r);
    return (r >= 8'h80) ? 32'(r) - 32'h00000100 : 32'(r);
  endfunction
  task print_verdict;
    $display("errors=%0d checks=%0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task check(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // hold request until waitrequest seen low at an edge
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    read <= !w;
    write <= w;
    address <= a;
    writedata <= d;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (wreq === 1'b0) break;
    end
    rdv = rdata;
    read <= 1'b0;
    write <= 1'b0;
    if (n == 100) begin num_errors++; print_verdict; end
  endtask
  task st(input logic [4:0] e);
    bus(1'b0, OFF_STATE_STATUS, 32'h0);
    check({27'h0, rdv[4:0]}, {27'h0, e});
  endtask
  task strobe(input int b);
    bus(1'b1, OFF_STROBE, 32'h1 << b);
  endtask
  // w=0 carrier flag, w=1 ready-low, w=2 append valid
  task await(input int w, input logic e);
    int n;
    for (n = 0; n < 300; n++) begin
      @(posedge clk);
      if ((w == 0 ? cs : (w == 1 ? rdy : av)) === e) break;
    end
    if (n == 300) begin num_errors++; print_verdict; end
  endtask
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    check(osc, 1'b0);
    check(rdy, 1'b1);
    st(NUM_SLEEP);
    bus(1'b0, OFF_OSC_CTRL, 32'h0);
    check(rdv[1:0], 2'b10);
    strobe(STB_IDLE);
    await(1, 1'b0);
    check(osc, 1'b1);
    st(NUM_IDLE);
    strobe(STB_PWD);
    st(NUM_SLEEP);
    check(osc, 1'b0);
    bus(1'b1, OFF_OSC_CTRL, 32'h3);
    st(NUM_SLEEP);
    check(osc, 1'b1);
    bus(1'b1, OFF_OSC_CTRL, 32'h0);
    st(NUM_SLEEP);
    check(osc, 1'b1);
    bus(1'b1, OFF_OSC_CTRL, 32'h2);
    strobe(STB_IDLE);
    await(1, 1'b0);
    strobe(STB_RX);
    st(NUM_RX);
    check(sse, 1'b1);
    for (m = 0; m < 3; m++) begin
      bus(1'b1, OFF_CHAN_CTRL, {18'h0, DOUT_CS, 8'(m) | 8'h10});
      lfsr <= next(lfsr);
      level <= 8'h80 | {3'h0, lfsr[4:0]};
      pkt <= (m == 2);
      await(0, 1'b0);
      check(cs, 1'b0);
      check(sse, 1'b0);
      strobe(STB_TX);
      st(m == 2 ? NUM_RX : NUM_TX);
      strobe(STB_RX);
      level <= {2'b00, lfsr[5:0]};
      await(0, 1'b1);
      check(dout, 1'b1);
      check(sse, 1'b1);
      check(cca, m == 0);
      strobe(STB_TX);
      st(m == 0 ? NUM_TX : NUM_RX);
      if (m == 0) begin
        txu <= 1'b1;
        repeat (4) @(posedge clk);
        txu <= 1'b0;
        st(NUM_IDLE);
      end
      if (m == 1) begin
        level <= 8'h80 | {3'h0, lfsr[9:5]};
        await(0, 1'b0);
        st(NUM_RX);
      end
      strobe(STB_RX);
    end
    strobe(STB_RESET);
    st(NUM_SLEEP);
    bus(1'b0, OFF_CHAN_CTRL, 32'h0);
    check(rdv[13:0], {RST_DOUT_SEL, 3'h0, RST_SYNC_MODE, RST_CCA_MODE});
    // raise the absolute point: front gain first, digital gain after; relative step 6 dB
    bus(1'b1, OFF_AGC_CTRL, 32'h000001E3);
    bus(1'b1, OFF_AGC_CTRL, 32'h000001FB);
    level <= 8'h90;
    await(0, 1'b0);
    repeat (16) @(posedge clk);
    level <= 8'hB0;
    await(0, 1'b1);
    bus(1'b0, OFF_PKT_STATUS, 32'h0);
    check({rdv[3], rdv[1]}, 2'b01);
    bus(1'b0, OFF_SIG_STATUS, 32'h0);
    check(half_db(rdv[7:0]), 32'hFFFFFFB0);
    level <= 8'h90;
    await(0, 1'b0);
    bus(1'b1, OFF_CHAN_CTRL, 32'h00000020);
    bus(1'b0, OFF_LQI_STATUS, 32'h0);
    pkt <= 1'b0;
    await(2, 1'b1);
    check(ab, 8'h90);
    @(posedge clk);
    check(av, 1'b1);
    check(ab, {1'b0, rdv[6:0]});
    bus(1'b0, 8'h3C, 32'h0);
    check(rdv, 32'h0);
    print_verdict;
  end
endmodule
